/* core/ddrsp_pkg.sv */
package ddrsp_pkg;

  // ----------------------------------------
  // Organisation (wide variant)
  // ----------------------------------------
  localparam int DATA_W     = 36;
  localparam int ADDR_W     = 19;
  localparam int LANES      = 4;
  localparam int LANE_W     = 9;
  localparam int BURST_LEN  = 2;
  localparam int PAIR_W     = DATA_W * BURST_LEN;
  localparam int MEM_DEPTH  = 1 << ADDR_W;

  // ----------------------------------------
  // Read path buffering
  // ----------------------------------------
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [DATA_W-1:0] DATA_RST  = 36'h0_0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 19'h0_0000;
  localparam logic [LANES-1:0]  LANES_OFF = 4'hf;

  // ----------------------------------------
  // State machines
  // ----------------------------------------
  typedef enum logic [2:0] {
    WR_IDLE  = 3'h1,
    WR_WORD0 = 3'h2,
    WR_WORD1 = 3'h4
  } ddrsp_wr_t;

  typedef enum logic [1:0] {
    OUT_IDLE   = 2'h1,
    OUT_SECOND = 2'h2
  } ddrsp_out_t;

endpackage

/* core/ddrsp_stream_if.sv */
`timescale 1ns/1ps
interface ddrsp_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* core/ddrsp_edge.sv */
`timescale 1ns/1ps
module ddrsp_edge
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // Sampled level and its rising edge
  input  wire logic level,
  output logic      rise
);

  logic prev_reg;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      prev_reg <= 1'b1;
    else
      prev_reg <= level;
  end

  assign rise = level & ~prev_reg;

endmodule

/* core/ddrsp_fifo.sv */
`timescale 1ns/1ps
module ddrsp_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // Filling and draining sides
  ddrsp_stream_if.snk fill,
  ddrsp_stream_if.src drain
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             full;
  logic             empty;

  assign full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                 (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty = (wr_ptr_reg == rd_ptr_reg);

  assign fill.ready  = ~full;
  assign drain.valid = ~empty;
  assign drain.data  = store_reg[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clock)
  begin
    if (fill.valid && !full)
      store_reg[wr_ptr_reg[AW-1:0]] <= fill.data;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      wr_ptr_reg <= '0;
    else if (fill.valid && !full)
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      rd_ptr_reg <= '0;
    else if (drain.ready && !empty)
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
  end

endmodule

/* core/ddrsp_port.sv */
// How it works
// RULE1 - Write data taken on both input clock rises
// RULE2 - Controller pulls load low with address, direction
// RULE3 - Every transaction moves a burst of two
// RULE4 - Load low: select high reads, low writes
// RULE5 - Address sampled only on positive input clock
// RULE6 - Nineteen address bits, two arrays, one word each
// RULE7 - Each active-low select gates one nine-bit lane
// RULE8 - Selects sampled on same edge as data
// RULE9 - Deselected lanes keep their stored contents
// RULE10 - Address ignored while no transaction is loaded
// RULE11 - Read data timed by output clock pair
// RULE12 - Accesses start on input clock; single mode uses it
// RULE13 - Free-running echo clock follows the data clock
// RULE14 - Second read word on opposite output edge
`timescale 1ns/1ps
module ddrsp_port
  import ddrsp_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // Input and output clock pairs, sampled
  input  wire logic              in_clk,
  input  wire logic              in_clk_n,
  input  wire logic              out_clk,
  input  wire logic              out_clk_n,
  input  wire logic              single_clk_mode,
  // Command and write side
  input  wire logic              load_strobe_n,
  input  wire logic              read_write,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic [LANES-1:0]  byte_lane_write_sel_n,
  // Read side
  output logic      [DATA_W-1:0] rd_data,
  output logic                   rd_data_valid,
  output logic                   read_ready,
  output logic                   echo_clk,
  output logic                   echo_clk_n
);

  // ----------------------------------------
  // Clock edge detection
  // ----------------------------------------
  logic k_rise;
  logic kn_rise;
  logic c_rise;
  logic cn_rise;
  logic oclk_rise;
  logic oclkn_rise;

  ddrsp_edge u_edge_k  (.clock(clock), .sys_rst(sys_rst), .level(in_clk),    .rise(k_rise));
  ddrsp_edge u_edge_kn (.clock(clock), .sys_rst(sys_rst), .level(in_clk_n),  .rise(kn_rise));
  ddrsp_edge u_edge_c  (.clock(clock), .sys_rst(sys_rst), .level(out_clk),   .rise(c_rise));
  ddrsp_edge u_edge_cn (.clock(clock), .sys_rst(sys_rst), .level(out_clk_n), .rise(cn_rise));

  assign oclk_rise  = single_clk_mode ? k_rise  : c_rise;   // [RULE12] [RULE11]
  assign oclkn_rise = single_clk_mode ? kn_rise : cn_rise;  // [RULE12] [RULE11]

  // ----------------------------------------
  // Storage arrays and read buffer
  // ----------------------------------------
  logic [DATA_W-1:0] mem_lo [MEM_DEPTH];
  logic [DATA_W-1:0] mem_hi [MEM_DEPTH];

  ddrsp_stream_if #(.W(PAIR_W)) rd_fill ();
  ddrsp_stream_if #(.W(PAIR_W)) rd_drain ();

  ddrsp_fifo #(.WIDTH(PAIR_W), .DEPTH(FIFO_DEPTH)) u_rd_fifo
  (
    .clock   (clock),
    .sys_rst (sys_rst),
    .fill    (rd_fill),
    .drain   (rd_drain)
  );

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  ddrsp_wr_t         wr_state_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wd0_reg;
  logic [LANES-1:0]  wbs0_n_reg;
  logic              accept;
  logic              rd_accept;
  logic              wr_accept;
  logic              commit;

  assign accept    = k_rise && !load_strobe_n && (wr_state_reg == WR_IDLE);  // [RULE12]
  assign rd_accept = accept && read_write && rd_fill.ready;                 // [RULE4]
  assign wr_accept = accept && !read_write;                                 // [RULE4]
  assign commit    = kn_rise && (wr_state_reg == WR_WORD1);

  // Both burst words read at once, one from each array
  assign rd_fill.valid = rd_accept;                                         // [RULE3] [RULE6]
  assign rd_fill.data  = {mem_lo[addr], mem_hi[addr]};
  assign read_ready    = rd_fill.ready;

  // Address only taken with an accepted load
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      addr_reg <= ADDR_RST;
    else if (accept)
      addr_reg <= addr;  // [RULE5] [RULE10]
  end

  // ----------------------------------------
  // Write burst sequencing
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      wr_state_reg <= WR_IDLE;
    else
    begin
      case (wr_state_reg)
        WR_IDLE:
          if (wr_accept)
            wr_state_reg <= WR_WORD0;  // [RULE4]
        WR_WORD0:
          if (k_rise)
            wr_state_reg <= WR_WORD1;
        WR_WORD1:
          if (kn_rise)
            wr_state_reg <= WR_IDLE;   // [RULE3]
        default:
          wr_state_reg <= WR_IDLE;
      endcase
    end
  end

  // First word and its selects on the positive edge
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wd0_reg    <= DATA_RST;
      wbs0_n_reg <= LANES_OFF;
    end
    else if (k_rise && (wr_state_reg == WR_WORD0))
    begin
      wd0_reg    <= wr_data;                // [RULE1]
      wbs0_n_reg <= byte_lane_write_sel_n;  // [RULE8]
    end
  end

  always_ff @(posedge clock)
  begin
    if (commit)
    begin
      for (int i = 0; i < LANES; i++)
      begin
        if (!wbs0_n_reg[i])
          mem_lo[addr_reg][i*LANE_W +: LANE_W] <= wd0_reg[i*LANE_W +: LANE_W];  // [RULE7] [RULE9]
      end
    end
  end

  // Second word written with selects of the negative edge
  always_ff @(posedge clock)
  begin
    if (commit)
    begin
      for (int i = 0; i < LANES; i++)
      begin
        if (!byte_lane_write_sel_n[i])
          mem_hi[addr_reg][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];  // [RULE1] [RULE8]
      end
    end
  end

  // ----------------------------------------
  // Read data output
  // ----------------------------------------
  ddrsp_out_t        out_state_reg;
  logic [DATA_W-1:0] rd_data_reg;
  logic [DATA_W-1:0] word1_reg;
  logic              rd_valid_reg;
  logic              pop;

  assign rd_drain.ready = oclk_rise && (out_state_reg == OUT_IDLE);
  assign pop            = rd_drain.ready && rd_drain.valid;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      out_state_reg <= OUT_IDLE;
      rd_data_reg   <= DATA_RST;
      word1_reg     <= DATA_RST;
      rd_valid_reg  <= 1'b0;
    end
    else
    begin
      case (out_state_reg)
        OUT_IDLE:
          if (pop)
          begin
            rd_data_reg   <= rd_drain.data[PAIR_W-1:DATA_W];  // [RULE11]
            word1_reg     <= rd_drain.data[DATA_W-1:0];
            rd_valid_reg  <= 1'b1;
            out_state_reg <= OUT_SECOND;
          end
          else if (oclk_rise)
            rd_valid_reg <= 1'b0;
        OUT_SECOND:
          if (oclkn_rise)
          begin
            rd_data_reg   <= word1_reg;  // [RULE14]
            out_state_reg <= OUT_IDLE;
          end
        default:
          out_state_reg <= OUT_IDLE;
      endcase
    end
  end

  assign rd_data       = rd_data_reg;
  assign rd_data_valid = rd_valid_reg;

  // ----------------------------------------
  // Echo clocks
  // ----------------------------------------
  logic echo_reg;
  logic echo_n_reg;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      echo_reg   <= 1'b0;
      echo_n_reg <= 1'b1;
    end
    else
    begin
      echo_reg   <= single_clk_mode ? in_clk   : out_clk;    // [RULE13]
      echo_n_reg <= single_clk_mode ? in_clk_n : out_clk_n;  // [RULE13]
    end
  end

  assign echo_clk   = echo_reg;
  assign echo_clk_n = echo_n_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [LANE_W-1:0] hi_lane0_now;
  assign hi_lane0_now = mem_hi[addr_reg][LANE_W-1:0];

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_write_load;
    k_rise && !load_strobe_n && !read_write && (wr_state_reg == WR_IDLE);
  endsequence

  sequence s_word1_commit;
    (wr_state_reg == WR_WORD1) && kn_rise;
  endsequence

  property p_write_load;
    s_write_load |=> (wr_state_reg == WR_WORD0) && (addr_reg == $past(addr));
  endproperty
  a_write_load: assert property (p_write_load) // [RULE4]
    else $error("write load not accepted");

  property p_read_load;
    (k_rise && !load_strobe_n && read_write && (wr_state_reg == WR_IDLE) && read_ready)
      |-> rd_fill.valid ##1 (rd_drain.valid && (wr_state_reg == WR_IDLE));
  endproperty
  a_read_load: assert property (p_read_load) // [RULE4]
    else $error("read load not pushed");

  property p_word0;
    (k_rise && (wr_state_reg == WR_WORD0)) |=> (wd0_reg == $past(wr_data))
      && (wbs0_n_reg == $past(byte_lane_write_sel_n));
  endproperty
  a_word0: assert property (p_word0) // [RULE1]
    else $error("first write word not captured");

  property p_burst_two;
    s_word1_commit |=> (wr_state_reg == WR_IDLE);
  endproperty
  a_burst_two: assert property (p_burst_two) // [RULE3]
    else $error("burst did not end after two words");

  property p_addr_hold;
    !accept |=> $stable(addr_reg);
  endproperty
  a_addr_hold: assert property (p_addr_hold) // [RULE10]
    else $error("address moved without a load");

  property p_lane_written;
    (s_word1_commit and !byte_lane_write_sel_n[0])
      |=> (hi_lane0_now == $past(wr_data[LANE_W-1:0]));
  endproperty
  a_lane_written: assert property (p_lane_written) // [RULE7]
    else $error("selected lane not written");

  property p_lane_kept;
    (s_word1_commit and byte_lane_write_sel_n[0]) |=> (hi_lane0_now == $past(hi_lane0_now));
  endproperty
  a_lane_kept: assert property (p_lane_kept) // [RULE9]
    else $error("deselected lane changed");

  property p_first_word;
    pop |=> rd_data_valid && (rd_data == $past(rd_drain.data[PAIR_W-1:DATA_W]));
  endproperty
  a_first_word: assert property (p_first_word) // [RULE11]
    else $error("first read word wrong");

  property p_second_word;
    ((out_state_reg == OUT_SECOND) && oclkn_rise) |=> (rd_data == $past(word1_reg))
      && (out_state_reg == OUT_IDLE);
  endproperty
  a_second_word: assert property (p_second_word) // [RULE14]
    else $error("second read word wrong");

  property p_echo;
    (single_clk_mode && $stable(single_clk_mode)) |=> (echo_clk == $past(in_clk));
  endproperty
  a_echo: assert property (p_echo) // [RULE13]
    else $error("echo clock not following input clock");

endmodule

/* bench/ddrsp_ctrl_model.sv */
`timescale 1ns/1ps
module ddrsp_ctrl_model
  import ddrsp_pkg::*;
(
  // Clock
  input  wire logic              clock,
  // Clock pairs
  output logic                   in_clk,
  output logic                   in_clk_n,
  output logic                   out_clk,
  output logic                   out_clk_n,
  // Command and write data
  output logic                   load_strobe_n,
  output logic                   read_write,
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] wr_data,
  output logic      [LANES-1:0]  byte_lane_write_sel_n
);
  logic       out_run = 1'b1;
  logic [1:0] oph     = 2'h1;

  initial
  begin
    in_clk = 1'b0;
    in_clk_n = 1'b1;
    load_strobe_n = 1'b1;
    read_write = 1'b0;
    addr = ADDR_RST;
    wr_data = DATA_RST;
    byte_lane_write_sel_n = LANES_OFF;
  end

  // ----------------------------------------
  // Output clock pair, parks low when halted
  // ----------------------------------------
  always @(negedge clock)
    if (out_run || oph[1])
      oph <= oph + 2'h1;
  assign out_clk   = oph[1];
  assign out_clk_n = ~oph[1];

  // ----------------------------------------
  // One input clock period
  // ----------------------------------------
  task automatic kcycle(input logic ld_n, rw, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d0, d1, input logic [LANES-1:0] s0, s1);
    @(negedge clock);
    in_clk = 1'b1;
    in_clk_n = 1'b0;
    load_strobe_n = ld_n;
    read_write = rw;
    addr = a;
    wr_data = d0;
    byte_lane_write_sel_n = s0;
    repeat (2) @(negedge clock);
    in_clk = 1'b0;
    in_clk_n = 1'b1;
    load_strobe_n = 1'b1;
    read_write = ~rw;
    addr = ~a;
    wr_data = d1;
    byte_lane_write_sel_n = s1;
    @(negedge clock);
  endtask
endmodule

/* bench/ddrsp_port_tb.sv */
`timescale 1ns/1ps
module ddrsp_port_tb;
  import ddrsp_pkg::*;

  logic              clock = 1'b0;
  logic              sys_rst = 1'b1;
  logic              single_clk_mode = 1'b0;
  logic              in_clk, in_clk_n, out_clk, out_clk_n, load_strobe_n, read_write;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data, rd_data, e;
  logic [LANES-1:0]  byte_lane_write_sel_n;
  logic              rd_data_valid, read_ready, echo_clk, echo_clk_n, rst_s;
  logic [1:0]        cur, prv = 2'h3;
  logic [DATA_W-1:0] mem_lo [int];
  logic [DATA_W-1:0] mem_hi [int];
  logic [DATA_W-1:0] exp_q [$];
  logic [ADDR_W-1:0] adr [6];
  int                n_mismatch = 0;
  int                checked = 0;
  int                cyc = 0;
  int unsigned       seed;

  always #25 clock = ~clock;

  ddrsp_ctrl_model ctrl_inst (.clock(clock), .in_clk(in_clk), .in_clk_n(in_clk_n),
    .out_clk(out_clk), .out_clk_n(out_clk_n), .load_strobe_n(load_strobe_n),
    .read_write(read_write), .addr(addr), .wr_data(wr_data),
    .byte_lane_write_sel_n(byte_lane_write_sel_n));

  ddrsp_port ddrsp_port_inst (.clock(clock), .sys_rst(sys_rst), .in_clk(in_clk),
    .in_clk_n(in_clk_n), .out_clk(out_clk), .out_clk_n(out_clk_n),
    .single_clk_mode(single_clk_mode), .load_strobe_n(load_strobe_n),
    .read_write(read_write), .addr(addr), .wr_data(wr_data),
    .byte_lane_write_sel_n(byte_lane_write_sel_n), .rd_data(rd_data),
    .rd_data_valid(rd_data_valid), .read_ready(read_ready), .echo_clk(echo_clk),
    .echo_clk_n(echo_clk_n));

  task automatic check(input logic [DATA_W-1:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  function automatic logic [DATA_W-1:0] rnd();
    rnd = DATA_W'({$urandom(), $urandom()});
  endfunction

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, d,
                                               input logic [LANES-1:0] s);
    merge = o;
    for (int i = 0; i < LANES; i++)
      if (!s[i])
        merge[i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
  endfunction

  // ----------------------------------------
  // Transfers
  // ----------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0, d1,
                    input logic [LANES-1:0] s0, s1, input logic ld2);
    ctrl_inst.kcycle(1'b0, 1'b0, a, rnd(), rnd(), s0, s1);
    ctrl_inst.kcycle(ld2, 1'b1, a, d0, d1, s0, s1);
    mem_lo[a] = merge(mem_lo[a], d0, s0);
    mem_hi[a] = merge(mem_hi[a], d1, s1);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    exp_q.push_back(mem_lo[a]);
    exp_q.push_back(mem_hi[a]);
    ctrl_inst.kcycle(1'b0, 1'b1, a, rnd(), rnd(), 4'h0, 4'h0);
  endtask

  // Idle periods carry random address and live selects
  task automatic drain(input int t);
    for (int i = 0; i < 60 && exp_q.size() > 0; i++)
      ctrl_inst.kcycle(1'b1, 1'b0, ADDR_W'($urandom()), rnd(), rnd(), 4'h0, 4'h0);
    repeat (3) ctrl_inst.kcycle(1'b1, 1'b0, ADDR_W'($urandom()), rnd(), rnd(), 4'h0, 4'h0);
    check(DATA_W'(exp_q.size()), 36'h0);
    $display("test %0d done", t);
  endtask

  // ----------------------------------------
  // Output watcher
  // ----------------------------------------
  always @(posedge clock)
  begin
    cur = single_clk_mode ? {in_clk, in_clk_n} : {out_clk, out_clk_n};
    rst_s = sys_rst;
    #1;
    if (!rst_s)
    begin
      check({34'h0, echo_clk, echo_clk_n}, {34'h0, cur});
      if (rd_data_valid === 1'b1 && (cur & ~prv) != 2'h0)
      begin
        e = (exp_q.size() > 0) ? exp_q.pop_front() : ~rd_data;
        check(rd_data, e);
      end
    end
    prv = rst_s ? 2'h3 : cur;
  end

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  initial
  begin
    seed = $urandom(22);
    repeat (4) @(negedge clock);
    sys_rst = 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      adr[i] = (i == 0) ? '0 : (i == 1) ? '1 : ADDR_W'($urandom());
      wr(adr[i], rnd(), rnd(), 4'h0, 4'h0, 1'b1);
      rd(adr[i]);
    end
    drain(1);
    foreach (adr[i])
      rd(adr[i]);
    drain(2);
    for (int i = 0; i < LANES; i++)
    begin
      wr(adr[2], rnd(), rnd(), ~(4'h1 << i), 4'h1 << i, 1'b1);
      rd(adr[2]);
    end
    drain(3);
    wr(adr[3], rnd(), rnd(), 4'h0, 4'h0, 1'b0);
    rd(adr[3]);
    drain(4);
    ctrl_inst.out_run = 1'b0;
    repeat (FIFO_DEPTH)
      rd(adr[4]);
    check({35'h0, read_ready}, 36'h0);
    ctrl_inst.kcycle(1'b0, 1'b1, adr[5], rnd(), rnd(), 4'h0, 4'h0);
    ctrl_inst.out_run = 1'b1;
    drain(5);
    check({35'h0, read_ready}, 36'h1);
    ctrl_inst.out_run = 1'b0;
    repeat (4) @(negedge clock);
    single_clk_mode = 1'b1;
    rd(adr[0]);
    rd(adr[5]);
    drain(6);
    complete_run();
  end
endmodule
